//--- core/osq_pkg.sv
// package for the operation status group and output queue
// assumes one 100 MHz clock and a command decoder outside the block
package osq_pkg;

    localparam int unsigned REG_W     = 16;
    localparam int unsigned SEL_W     = 3;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned QDEPTH    = 64;
    localparam int unsigned QADDR_W   = 6;
    localparam int unsigned QCOUNT_W  = 7;

    // register selectors carried by a query or write command
    typedef enum logic [2:0] {
        OSQ_SEL_CONDITION = 3'h0,
        OSQ_SEL_RISING    = 3'h1,
        OSQ_SEL_FALLING   = 3'h2,
        OSQ_SEL_EVENT     = 3'h3,
        OSQ_SEL_ENABLE    = 3'h4
    } osq_sel_t;

    // operation condition bit positions
    localparam int unsigned BIT_CAL      = 0;
    localparam int unsigned BIT_RANGING  = 2;
    localparam int unsigned BIT_MEAS     = 4;
    localparam int unsigned BIT_CELL1    = 8;
    localparam int unsigned BIT_CALLPROC = 9;
    localparam int unsigned BIT_CELL2    = 10;
    localparam int unsigned BIT_PROGRUN  = 14;
    localparam int unsigned BIT_UNUSED15 = 15;

    localparam logic [15:0] REG_RESET  = 16'h0000;
    localparam logic [15:0] USED_MASK  = 16'h4711;
    localparam int unsigned STB_MAV    = 4;
    localparam int unsigned STB_OPER   = 7;

    // summary bits that arrive from subsidiary groups and the controller
    typedef struct packed {
        logic prog_running;
        logic cell2_summary;
        logic callproc_summary;
        logic cell1_summary;
        logic meas_summary;
        logic cal_summary;
    } osq_sources_t;

    // register command from the remote interface parser
    typedef struct packed {
        logic              valid;
        logic              write;
        osq_sel_t          sel;
        logic [REG_W-1:0]  wdata;
    } osq_cmd_t;

endpackage : osq_pkg

//--- core/osq_queue_mem.sv
// storage array of the output queue
// assumes the caller never writes when full; read data is registered
`timescale 1ns/10ps
module osq_queue_mem
    import osq_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_we,
    input  wire logic [QADDR_W-1:0]  i_waddr,
    input  wire logic [DATA_W-1:0]   i_wdata,
    input  wire logic [QADDR_W-1:0]  i_raddr,
    output logic      [DATA_W-1:0]   o_rdata
);

    logic [DATA_W-1:0] mem_q [QDEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rdata <= mem_q[i_raddr];
    end

endmodule : osq_queue_mem

//--- core/osq_top.sv
// operation status group, message-available bit and output queue
// assumes a parser that issues register commands and response bytes;
// source summary bits may come from other logic and are synchronised
`timescale 1ns/10ps
module osq_top
    import osq_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire osq_sources_t        i_sources,
    input  wire osq_cmd_t            i_cmd,
    input  wire logic                i_clear_status,
    input  wire logic                i_resp_valid,
    input  wire logic [DATA_W-1:0]   i_resp_data,
    input  wire logic                i_queue_clear,
    input  wire logic                i_read_req,
    output logic                     o_resp_ready,
    output logic                     o_cmd_ready,
    output logic                     o_reg_valid,
    output logic      [REG_W-1:0]    o_reg_data,
    output logic                     o_read_valid,
    output logic      [DATA_W-1:0]   o_read_data,
    output logic                     o_message_available,
    output logic                     o_group_summary_bit,
    output logic      [7:0]          o_stb_bits
);

    logic                   rst_s1_q;
    logic                   rst_n_q;
    osq_sources_t           src_s1_q;
    osq_sources_t           src_s2_q;
    logic [REG_W-1:0]       cond_d;
    logic [REG_W-1:0]       cond_q;
    logic [REG_W-1:0]       rise_q;
    logic [REG_W-1:0]       fall_q;
    logic [REG_W-1:0]       event_q;
    logic [REG_W-1:0]       event_set;
    logic [REG_W-1:0]       enable_q;
    logic                   summary_d;
    logic                   cmd_take;
    logic                   ev_query;
    logic [QADDR_W-1:0]     wptr_q;
    logic [QADDR_W-1:0]     rptr_q;
    logic [QCOUNT_W-1:0]    count_q;
    logic                   push;
    logic                   pop;
    logic                   pop_pend_q;
    logic [DATA_W-1:0]      mem_rdata;

    function automatic logic [REG_W-1:0] keep_used(
        input logic [REG_W-1:0] v
    );
        keep_used = v & USED_MASK;
    endfunction : keep_used

    // reset release through two flops
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // sources may be driven from other domains
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            src_s1_q <= '0;
            src_s2_q <= '0;
        end else begin
            src_s1_q <= i_sources;
            src_s2_q <= src_s1_q;
        end
    end

    always_comb begin
        cond_d                = REG_RESET;
        cond_d[BIT_CAL]       = src_s2_q.cal_summary;
        cond_d[BIT_MEAS]      = src_s2_q.meas_summary;
        cond_d[BIT_CELL1]     = src_s2_q.cell1_summary;
        cond_d[BIT_CALLPROC]  = src_s2_q.callproc_summary;
        cond_d[BIT_CELL2]     = src_s2_q.cell2_summary;
        cond_d[BIT_PROGRUN]   = src_s2_q.prog_running;
        // ranging error has no condition source
        cond_d[BIT_RANGING]   = 1'b0;
        cond_d[BIT_UNUSED15]  = 1'b0;
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cond_q <= REG_RESET;
        end else begin
            cond_q <= cond_d;
        end
    end

    // register commands wait while a response is pending
    assign cmd_take = i_cmd.valid && o_cmd_ready;
    assign ev_query = cmd_take && !i_cmd.write
                      && (i_cmd.sel == OSQ_SEL_EVENT);

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rise_q   <= REG_RESET;
            fall_q   <= REG_RESET;
            enable_q <= REG_RESET;
        end else if (cmd_take && i_cmd.write) begin
            unique case (i_cmd.sel)
                OSQ_SEL_RISING:  rise_q   <= keep_used(i_cmd.wdata);
                OSQ_SEL_FALLING: fall_q   <= keep_used(i_cmd.wdata);
                // zero written here clears the enable mask
                OSQ_SEL_ENABLE:  enable_q <= keep_used(i_cmd.wdata);
                default: ;
            endcase
        end
    end

    // filtered edges of the condition register
    genvar gi;
    generate
        for (gi = 0; gi < REG_W; gi++) begin : g_edge
            assign event_set[gi] = (cond_d[gi] && !cond_q[gi] && rise_q[gi])
                                || (!cond_d[gi] && cond_q[gi]
                                    && fall_q[gi]);
        end
    endgenerate

    // a new edge in the clearing cycle survives the clear
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            event_q <= REG_RESET;
        end else if (ev_query || i_clear_status) begin
            event_q <= keep_used(event_set);
        end else begin
            event_q <= keep_used(event_q | event_set);
        end
    end

    assign summary_d = |(event_q & enable_q);

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_group_summary_bit <= 1'b0;
        end else begin
            o_group_summary_bit <= summary_d;
        end
    end

    // register query answer, one cycle after the command is taken
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_reg_valid <= 1'b0;
            o_reg_data  <= REG_RESET;
        end else begin
            o_reg_valid <= cmd_take && !i_cmd.write;
            if (cmd_take && !i_cmd.write) begin
                unique case (i_cmd.sel)
                    OSQ_SEL_CONDITION: o_reg_data <= cond_q;
                    OSQ_SEL_RISING:    o_reg_data <= rise_q;
                    OSQ_SEL_FALLING:   o_reg_data <= fall_q;
                    OSQ_SEL_EVENT:     o_reg_data <= event_q;
                    OSQ_SEL_ENABLE:    o_reg_data <= enable_q;
                    default:           o_reg_data <= REG_RESET;
                endcase
            end
        end
    end

    // output queue
    assign push = i_resp_valid && o_resp_ready && !i_queue_clear;
    assign pop  = i_read_req && (count_q != '0) && !i_queue_clear;

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else if (i_queue_clear) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
            count_q <= count_q + QCOUNT_W'(push) - QCOUNT_W'(pop);
        end
    end

    osq_queue_mem u_mem (
        .i_clk   (i_clk),
        .i_we    (push),
        .i_waddr (wptr_q),
        .i_wdata (i_resp_data),
        .i_raddr (rptr_q),
        .o_rdata (mem_rdata)
    );

    // the memory answers one cycle after the pop
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pop_pend_q <= 1'b0;
        end else begin
            pop_pend_q <= pop;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_read_valid <= 1'b0;
            o_read_data  <= '0;
        end else begin
            o_read_valid <= pop_pend_q;
            if (pop_pend_q) begin
                o_read_data <= mem_rdata;
            end
        end
    end

    // registered view of the queue level and of the summary bit in the status byte; lags count by one cycle
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_message_available <= 1'b0;
            o_resp_ready        <= 1'b0;
            o_cmd_ready         <= 1'b0;
            o_stb_bits          <= '0;
        end else begin
            o_message_available <= (count_q != '0);
            // queue holding 62 or more bytes back-pressures the response source
            o_resp_ready <= (count_q < QCOUNT_W'(QDEPTH - 2));
            // no new message is processed before pending data is read
            o_cmd_ready  <= (count_q == '0) && !push;
            o_stb_bits             <= '0;
            o_stb_bits[STB_MAV]    <= (count_q != '0);
            o_stb_bits[STB_OPER]   <= summary_d;
        end
    end

endmodule : osq_top

//--- tb/osq_props.sv
// assertions on the ports of the status group and output queue
// assumes binding to osq_top, one clock and an active-low reset
`timescale 1ns/10ps
module osq_props
    import osq_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    input wire osq_cmd_t          i_cmd,
    input wire logic              i_clear_status,
    input wire logic              i_resp_valid,
    input wire logic              i_queue_clear,
    input wire logic              i_read_req,
    input wire logic              o_resp_ready,
    input wire logic              o_cmd_ready,
    input wire logic              o_reg_valid,
    input wire logic [REG_W-1:0]  o_reg_data,
    input wire logic              o_read_valid,
    input wire logic              o_message_available,
    input wire logic              o_group_summary_bit,
    input wire logic [7:0]        o_stb_bits
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_oper_to_stb: assert property (
        o_stb_bits[7] == o_group_summary_bit)
        else $error("status byte bit 7 differs from summary");
    a_mav_to_stb: assert property (
        o_message_available |-> ##[0:1] o_stb_bits[4])
        else $error("status byte bit 4 misses message available");
    a_msb_zero: assert property (
        o_reg_valid |-> !o_reg_data[15])
        else $error("register bit 15 read as one");
    a_unused_zero: assert property (
        o_reg_valid |-> (o_reg_data & ~USED_MASK) == 16'h0000)
        else $error("unused register bit read as one");
    a_query_answer: assert property (
        i_cmd.valid && o_cmd_ready && !i_cmd.write |-> ##[1:2] o_reg_valid)
        else $error("query got no answer");
    a_push_stall: assert property (
        i_resp_valid && o_resp_ready |=> !o_cmd_ready)
        else $error("commands accepted with reply pending");
    a_push_mav: assert property (
        i_resp_valid && o_resp_ready && !i_queue_clear
        |-> ##[1:2] o_message_available)
        else $error("queued byte not flagged");
    a_clear_mav: assert property (
        i_queue_clear |-> ##[1:2] !o_message_available)
        else $error("queue clear left data flagged");
    a_pop_answer: assert property (
        i_read_req && o_message_available |-> ##[1:3] o_read_valid)
        else $error("queue read got no byte");
    a_cls_summary: assert property (
        i_clear_status |-> ##[1:3] !o_group_summary_bit)
        else $error("clear status left summary set");
endmodule : osq_props
bind osq_top osq_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_cmd(i_cmd), .i_clear_status(i_clear_status),
    .i_resp_valid(i_resp_valid), .i_queue_clear(i_queue_clear),
    .i_read_req(i_read_req), .o_resp_ready(o_resp_ready),
    .o_cmd_ready(o_cmd_ready), .o_reg_valid(o_reg_valid),
    .o_reg_data(o_reg_data), .o_read_valid(o_read_valid),
    .o_message_available(o_message_available),
    .o_group_summary_bit(o_group_summary_bit), .o_stb_bits(o_stb_bits));

//--- tb/osq_ctrl_model.sv
// remote controller reading the output queue one byte at a time
// assumes inputs settle before the falling edge
`timescale 1ns/10ps
module osq_ctrl_model (
    input  wire logic i_clk,
    input  wire logic i_enable,
    input  wire logic i_message_available,
    input  wire logic i_read_valid,
    output logic      o_read_req
);
    logic waiting_q;
    initial begin
        o_read_req = 1'b0;
        waiting_q  = 1'b0;
    end
    // one read in flight: the next waits for the byte, never guesses
    always @(negedge i_clk) begin
        if (o_read_req) begin
            o_read_req <= 1'b0;
        end else if (i_read_valid) begin
            waiting_q <= 1'b0;
        end else if (i_enable && i_message_available && !waiting_q) begin
            o_read_req <= 1'b1;
            waiting_q  <= 1'b1;
        end
    end
endmodule : osq_ctrl_model

//--- tb/operation_status_and_output_queue_test.sv
// self-checking bench for the status group and output queue
// assumes osq_top and the controller model; inputs change at negedge
`timescale 1ns/10ps
module operation_status_and_output_queue_test;
    import osq_pkg::*;
    logic i_clk, i_rst_n, i_clear_status, i_resp_valid, i_queue_clear;
    logic rd_go, o_resp_ready, o_cmd_ready, o_reg_valid, o_read_valid;
    logic o_message_available, o_group_summary_bit, read_req;
    logic [DATA_W-1:0] i_resp_data, o_read_data;
    logic [REG_W-1:0]  o_reg_data;
    logic [7:0]        o_stb_bits;
    osq_sources_t      i_sources;
    osq_cmd_t          i_cmd;
    int num_errors = 0, checks_done = 0, cyc = 0, k, n, got;
    int unsigned pos[6] = '{BIT_CAL, BIT_MEAS, BIT_CELL1, BIT_CALLPROC,
                            BIT_CELL2, BIT_PROGRUN};
    logic [7:0] bytes[3] = '{8'hA5, 8'h3C, 8'h0F};

    osq_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sources(i_sources),
        .i_cmd(i_cmd), .i_clear_status(i_clear_status),
        .i_resp_valid(i_resp_valid), .i_resp_data(i_resp_data),
        .i_queue_clear(i_queue_clear), .i_read_req(read_req),
        .o_resp_ready(o_resp_ready), .o_cmd_ready(o_cmd_ready),
        .o_reg_valid(o_reg_valid), .o_reg_data(o_reg_data),
        .o_read_valid(o_read_valid), .o_read_data(o_read_data),
        .o_message_available(o_message_available),
        .o_group_summary_bit(o_group_summary_bit), .o_stb_bits(o_stb_bits));
    osq_ctrl_model u_ctrl (.i_clk(i_clk), .i_enable(rd_go),
        .i_message_available(o_message_available),
        .i_read_valid(o_read_valid), .o_read_req(read_req));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic settle(input int c);
        repeat (c) @(negedge i_clk);
    endtask : settle

    // waits out a pending reply, since commands are refused meanwhile
    task automatic reg_op(input logic wr, input osq_sel_t s,
                          input logic [15:0] wd, input logic [15:0] exp);
        int m;
        m = 0;
        while (o_cmd_ready !== 1'b1 && m < 200) begin
            settle(1);
            m++;
        end
        i_cmd <= '{valid: 1'b1, write: wr, sel: s, wdata: wd};
        settle(1);
        i_cmd.valid <= 1'b0;
        if (!wr) begin
            m = 0;
            while (o_reg_valid !== 1'b1 && m < 4) begin
                settle(1);
                m++;
            end
            chk(o_reg_data, exp);
        end
        // lets an edge pass so the next call never re-drives i_cmd at once
        settle(1);
    endtask : reg_op

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        i_rst_n = 1'b0;
        i_sources = '0;
        i_cmd = '0;
        {i_clear_status, i_resp_valid, i_queue_clear, rd_go} = 4'h0;
        i_resp_data = 8'h00;
        settle(16);
        i_rst_n = 1'b1;
        for (k = 0; k < 5; k++) reg_op(0, osq_sel_t'(k), 0, 16'h0000);
        reg_op(1, OSQ_SEL_RISING, 16'hFFFF, 0);
        reg_op(0, OSQ_SEL_RISING, 0, USED_MASK);
        reg_op(1, OSQ_SEL_ENABLE, 16'hFFFF, 0);
        reg_op(0, OSQ_SEL_ENABLE, 0, USED_MASK);
        for (k = 0; k < 6; k++) begin
            i_sources <= osq_sources_t'(6'h01 << k);
            settle(8);
            reg_op(0, OSQ_SEL_CONDITION, 0, 16'h0001 << pos[k]);
            chk(16'(o_stb_bits[7]), 16'h0001);
            reg_op(0, OSQ_SEL_EVENT, 0, 16'h0001 << pos[k]);
            settle(3);
            chk(16'(o_group_summary_bit), 16'h0000);
        end
        reg_op(1, OSQ_SEL_FALLING, 16'hFFFF, 0);
        i_sources <= '0;
        settle(8);
        chk(16'(o_group_summary_bit), 16'h0001);
        i_clear_status <= 1'b1;
        settle(1);
        i_clear_status <= 1'b0;
        settle(4);
        chk(16'(o_group_summary_bit), 16'h0000);
        reg_op(0, OSQ_SEL_EVENT, 0, 16'h0000);
        reg_op(1, OSQ_SEL_ENABLE, 16'h0000, 0);
        reg_op(0, OSQ_SEL_ENABLE, 0, 16'h0000);
        i_sources <= osq_sources_t'(6'h01);
        settle(8);
        chk(16'(o_group_summary_bit), 16'h0000);
        reg_op(0, OSQ_SEL_EVENT, 0, 16'h0001);
        for (k = 0; k < 3; k++) begin
            i_resp_valid <= 1'b1;
            i_resp_data  <= bytes[k];
            settle(1);
        end
        i_resp_valid <= 1'b0;
        settle(3);
        chk(16'(o_message_available), 16'h0001);
        chk(16'(o_stb_bits[4]), 16'h0001);
        chk(16'(o_cmd_ready), 16'h0000);
        chk(16'(o_resp_ready), 16'h0001);
        rd_go <= 1'b1;
        got = 0;
        for (n = 0; n < 60 && got < 3; n++) begin
            settle(1);
            if (o_read_valid === 1'b1) chk(16'(o_read_data), 16'(bytes[got++]));
        end
        chk(got[15:0], 16'h0003);
        settle(3);
        chk(16'(o_message_available), 16'h0000);
        rd_go <= 1'b0;
        i_resp_valid <= 1'b1;
        settle(2);
        i_resp_valid <= 1'b0;
        i_queue_clear <= 1'b1;
        settle(1);
        i_queue_clear <= 1'b0;
        settle(3);
        chk(16'(o_message_available), 16'h0000);
        tally_and_finish();
    end
endmodule : operation_status_and_output_queue_test
